// *** logic/apc_attribute_palette.v ***
// Attribute and palette stage of a display adapter: host register port,
// attribute selection, blinking, ninth dot, panning, palette and border.
// Assumes all inputs come from logic on clk_sys_in, one pel per clock,
// and host strobes are one-cycle pulses.
`timescale 1ns/1ps
`include "apc_consts.vh"

module apc_attribute_palette #(
   parameter PAN_DEPTH = 10 // Delay line stages, one beyond the largest pan
) (
   input wire clk_sys_in,
   input wire rst_in,
   // Host I/O port
   input wire host_write_in,
   input wire [5:0] host_wdata_in,
   input wire host_read_in,
   output wire [5:0] host_rdata_out,
   output wire host_rdata_oe_out,
   // Timing controller
   input wire display_enable_in,
   input wire vertical_retrace_in,
   input wire blank_in,
   input wire line_graphics_in,
   input wire cursor_in,
   input wire ninth_dot_in,
   // Pel data
   input wire [3:0] foreground_attribute_bits_in,
   input wire [3:0] background_attribute_bits_in,
   input wire condition_select_in,
   // Colour outputs: B, G, R, SB, SG, SR from bit 0 upward
   output wire [5:0] colour_out,
   output wire colour_oe_out
);

   ////////////////////////////////////////////////////////////////////////
   // Host visible registers
   reg [5:0] attribute_index; // Pointer and run bit
   reg index_toggle; // Low: next write goes to the index
   reg [5:0] palette_entries [0:15]; // Sixteen colour entries
   reg [3:0] attribute_mode_control; // Mode bits
   reg [5:0] border_colour; // Overscan colour
   reg [5:0] plane_enable_and_status_select; // Plane enables and status mux
   reg [3:0] horizontal_pel_shift; // Pan amount
   reg [5:0] status_data; // Registered read data
   reg status_oe; // Read data driven

   // Decoded mode bits
   wire bitmap_mode = attribute_mode_control[`APC_MODE_BITMAP];
   wire mono_attr = attribute_mode_control[`APC_MODE_MONO];
   wire line_gfx_en = attribute_mode_control[`APC_MODE_LINE_GFX];
   wire blink_en = attribute_mode_control[`APC_MODE_BLINK];
   wire palette_run = attribute_index[`APC_IDX_RUN_BIT];
   wire outputs_off = plane_enable_and_status_select[`APC_PLANE_STAT_LO];
   wire [4:0] reg_ptr = attribute_index[`APC_IDX_PTR_MSB:0];

   integer i;

   ////////////////////////////////////////////////////////////////////////
   // Index/data toggle and register writes
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         // Known state until the host programs the block
         index_toggle <= 1'b0;
         attribute_index <= `APC_RST_INDEX;
         attribute_mode_control <= `APC_RST_MODE;
         border_colour <= `APC_RST_BORDER;
         plane_enable_and_status_select <= `APC_RST_PLANE;
         horizontal_pel_shift <= `APC_RST_PAN;
         for (i = 0; i < 16; i = i + 1) begin
            palette_entries[i] <= `APC_RST_PALETTE;
         end
      end else if (host_write_in) begin
         // Every write flips the toggle, even with a read alongside
         index_toggle <= ~index_toggle;
         if (!index_toggle) begin
            // Index write
            attribute_index <= host_wdata_in;
         end else begin
            // Data write to the register under the pointer
            if (reg_ptr <= `APC_IDX_PALETTE_LAST) begin
               // Entries only load while the palette is off the display
               if (!palette_run) begin
                  palette_entries[reg_ptr[3:0]] <= host_wdata_in;
               end
            end else if (reg_ptr == `APC_IDX_MODE) begin
               attribute_mode_control <= host_wdata_in[3:0];
            end else if (reg_ptr == `APC_IDX_BORDER) begin
               border_colour <= host_wdata_in;
            end else if (reg_ptr == `APC_IDX_PLANE) begin
               plane_enable_and_status_select <= host_wdata_in;
            end else if (reg_ptr == `APC_IDX_PAN) begin
               horizontal_pel_shift <= host_wdata_in[3:0];
            end
         end
      end else if (host_read_in) begin
         // A status read points the next write at the index
         index_toggle <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Blink counters stepped by the start of vertical retrace
   reg retrace_prev; // Retrace one clock ago
   wire retrace_step = vertical_retrace_in & ~retrace_prev;
   wire char_blink_on; // Character blink phase
   wire cursor_blink_on; // Cursor blink phase

   // Edge detector state
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         retrace_prev <= 1'b0;
      end else begin
         retrace_prev <= vertical_retrace_in;
      end
   end

   // Character blink: 32 retraces, 16 on and 16 off
   apc_blink_div #(
      .BITS(5)
   ) u_char_blink (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .clear_in(~blink_en),
      .step_in(retrace_step),
      .phase_on_out(char_blink_on)
   );

   // Cursor blink: 16 retraces, held clear while outputs float
   apc_blink_div #(
      .BITS(4)
   ) u_cursor_blink (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .clear_in(outputs_off),
      .step_in(retrace_step),
      .phase_on_out(cursor_blink_on)
   );

   ////////////////////////////////////////////////////////////////////////
   // Attribute selection for one pel
   reg last_select; // Select bit of the previous pel, the eighth dot
   reg [3:0] next_pel_index; // Palette index for this pel
   reg [3:0] pel_index; // Registered palette index
   reg pel_select; // Effective select after ninth dot rule
   reg [3:0] bg_nibble; // Background nibble after blink rule

   // Remembers the eighth dot for the ninth
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         last_select <= 1'b0;
      end else if (!ninth_dot_in) begin
         last_select <= condition_select_in;
      end
   end

   // Combines mode, blink, cursor and plane enables into an index
   always @* begin
      pel_select = condition_select_in;
      bg_nibble = background_attribute_bits_in;
      next_pel_index = 4'h0;
      if (!bitmap_mode) begin
         // Text: ninth dot handling
         if (ninth_dot_in) begin
            if (line_gfx_en && line_graphics_in) begin
               pel_select = last_select;
            end else begin
               pel_select = 1'b0;
            end
         end
         if (blink_en) begin
            // Top bit marks a blinking cell, not intensity
            bg_nibble = {1'b0, background_attribute_bits_in[2:0]};
            if (background_attribute_bits_in[3] && !char_blink_on) begin
               pel_select = 1'b0;
            end
         end else begin
            bg_nibble = background_attribute_bits_in;
         end
         if (cursor_in && cursor_blink_on) begin
            pel_select = 1'b1;
         end
         next_pel_index = pel_select ? foreground_attribute_bits_in : bg_nibble;
      end else begin
         // Graphics: background nibble is ignored
         next_pel_index = foreground_attribute_bits_in;
         if (blink_en && !char_blink_on) begin
            next_pel_index[3] = ~foreground_attribute_bits_in[3];
         end
      end
      // Disabled planes read as zero
      next_pel_index = next_pel_index & plane_enable_and_status_select[3:0];
   end

   // Index and video qualifiers into the pipeline
   reg pel_de; // Display enable aligned with pel_index
   reg pel_blank; // Blank aligned with pel_index

   // First pipeline stage
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pel_index <= 4'h0;
         pel_de <= 1'b0;
         pel_blank <= 1'b0;
      end else begin
         pel_index <= next_pel_index;
         pel_de <= display_enable_in;
         pel_blank <= blank_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Horizontal panning
   reg [3:0] pan_amount; // Clamped pan value
   wire [3:0] pan_limit = (mono_attr && !bitmap_mode) ? `APC_PAN_MAX_MONO_TEXT :
      `APC_PAN_MAX_OTHER;
   wire [3:0] shifted_index; // Index after panning
   wire [1:0] shifted_ctl; // Enable and blank at fixed delay

   // Pan values beyond the mode limit stop at the limit
   always @* begin
      if (horizontal_pel_shift > pan_limit) begin
         pan_amount = pan_limit;
      end else begin
         pan_amount = horizontal_pel_shift;
      end
   end

   // Data stream taken from a tap that moves with the pan value
   apc_pel_shift #(
      .WIDTH(4),
      .DEPTH(PAN_DEPTH)
   ) u_pan_data (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .pel_in(pel_index),
      .shift_in(pan_amount),
      .pel_out(shifted_index)
   );

   // Video qualifiers always at the full delay, so borders stay put
   apc_pel_shift #(
      .WIDTH(2),
      .DEPTH(PAN_DEPTH)
   ) u_pan_ctl (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .pel_in({pel_de, pel_blank}),
      .shift_in(4'h0),
      .pel_out(shifted_ctl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Palette lookup and border
   reg [5:0] next_colour; // Colour for the coming pel
   reg [5:0] colour; // Registered colour outputs

   // Chooses palette, border or black
   always @* begin
      next_colour = 6'h00;
      if (!shifted_ctl[1] && !shifted_ctl[0]) begin
         next_colour = border_colour;
      end else if (shifted_ctl[1] && !shifted_ctl[0] && palette_run) begin
         next_colour = palette_entries[shifted_index];
      end
   end

   // Output stage
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         colour <= 6'h00;
      end else begin
         colour <= next_colour;
      end
   end

   assign colour_out = colour;
   assign colour_oe_out = ~outputs_off;

   ////////////////////////////////////////////////////////////////////////
   // Status port
   reg [1:0] next_stat_colour; // Colour pair for bits 5:4

   // Status colour multiplexer
   always @* begin
      case (plane_enable_and_status_select[`APC_PLANE_STAT_HI:`APC_PLANE_STAT_LO])
         2'b00: begin
            next_stat_colour = {colour[2], colour[0]};
         end
         2'b01: begin
            next_stat_colour = {colour[3], colour[1]};
         end
         2'b10: begin
            next_stat_colour = {colour[5], colour[4]};
         end
         default: begin
            next_stat_colour = 2'b00;
         end
      endcase
   end

   // Read data captured every clock, whether or not the host reads
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         status_data <= 6'h00;
         status_oe <= 1'b0;
      end else begin
         status_oe <= host_read_in;
         status_data <= 6'h00;
         status_data[`APC_STAT_DE_N] <= ~display_enable_in;
         status_data[`APC_STAT_RETRACE] <= vertical_retrace_in;
         status_data[5:4] <= next_stat_colour;
      end
   end

   assign host_rdata_out = status_data;
   assign host_rdata_oe_out = status_oe;

endmodule // apc_attribute_palette

// *** logic/apc_blink_div.v ***
// Retrace event divider giving a square blink phase.
// Assumes step_in is a one-cycle pulse per retrace start.
`timescale 1ns/1ps

module apc_blink_div #(
   parameter BITS = 5 // Counter width, period is two to this power
) (
   input wire clk_sys_in,
   input wire rst_in,
   input wire clear_in,
   input wire step_in,
   output wire phase_on_out
);

   ////////////////////////////////////////////////////////////////////////
   // Event counter
   reg [BITS-1:0] count;

   // Counts retrace events, held at zero while cleared
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         count <= {BITS{1'b0}};
      end else if (clear_in) begin
         count <= {BITS{1'b0}};
      end else if (step_in) begin
         count <= count + 1'b1;
      end
   end

   // First half of the period is the visible phase
   assign phase_on_out = ~count[BITS-1];

endmodule // apc_blink_div

// *** logic/apc_consts.vh ***
// Constants of the attribute and palette stage: register indices,
// field positions, reset values and blink counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// Register indices selected by the low five index bits
`define APC_IDX_PALETTE_LAST 5'h0f
`define APC_IDX_MODE 5'h10
`define APC_IDX_BORDER 5'h11
`define APC_IDX_PLANE 5'h12
`define APC_IDX_PAN 5'h13

// Index register fields
`define APC_IDX_PTR_MSB 4
`define APC_IDX_RUN_BIT 5

// Mode control fields
`define APC_MODE_BITMAP 0
`define APC_MODE_MONO 1
`define APC_MODE_LINE_GFX 2
`define APC_MODE_BLINK 3

// Plane enable and status select fields
`define APC_PLANE_STAT_LO 4
`define APC_PLANE_STAT_HI 5

// Status bit positions
`define APC_STAT_DE_N 0
`define APC_STAT_RETRACE 3

// Reset values
`define APC_RST_PALETTE 6'h00
`define APC_RST_INDEX 6'h00
`define APC_RST_MODE 4'h0
`define APC_RST_BORDER 6'h00
`define APC_RST_PLANE 6'h00
`define APC_RST_PAN 4'h0

// Pel panning limits
`define APC_PAN_MAX_MONO_TEXT 4'h9
`define APC_PAN_MAX_OTHER 4'h8

// Blink periods in retrace events
`define APC_CHAR_BLINK_PERIOD 32
`define APC_CURSOR_BLINK_PERIOD 16

`endif

// *** logic/apc_pel_shift.v ***
// Pel delay line with a selectable tap, used for horizontal panning.
// Assumes the shift value is stable while a line is shown.
`timescale 1ns/1ps

module apc_pel_shift #(
   parameter WIDTH = 4, // Bits per pel
   parameter DEPTH = 10 // Stages in the line
) (
   input wire clk_sys_in,
   input wire rst_in,
   input wire [WIDTH-1:0] pel_in,
   input wire [3:0] shift_in,
   output wire [WIDTH-1:0] pel_out
);

   ////////////////////////////////////////////////////////////////////////
   // Delay line, one flip-flop stage per pel
   reg [WIDTH-1:0] stage [0:DEPTH-1];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_stage
         // Each stage takes the one before it
         always @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
               stage[g] <= {WIDTH{1'b0}};
            end else if (g == 0) begin
               stage[g] <= pel_in;
            end else begin
               stage[g] <= stage[(g == 0) ? 0 : g - 1];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // A larger shift picks a younger stage, so later pels appear earlier
   localparam [31:0] LAST_TAP = DEPTH - 1; // Oldest stage, cut to the tap width below
   wire [3:0] tap = LAST_TAP[3:0] - shift_in;

   assign pel_out = stage[tap];

endmodule // apc_pel_shift

// *** tb/apc_attribute_palette_tb.sv ***
// Self-checking bench of the attribute and palette stage.
// Assumes the host model drives the register port and retrace.
`timescale 1ns/1ps

module apc_attribute_palette_tb;
   reg clk_sys_in; // Dot clock
   reg rst_in; // Reset
   reg de; // Display enable
   reg blank; // Blank
   reg lg; // Line graphics
   reg nd; // Ninth dot column
   reg cs; // Condition select
   reg cur; // Cursor
   reg [3:0] fg; // Foreground nibble
   reg [3:0] bg; // Background nibble
   wire hw, hr, vr, rd_oe, oe;
   wire [5:0] hwd, rdat, col;
   integer mismatches = 0, total_checks = 0, cycles = 0, n0, n1, i;
   reg [6:0] st;
   reg [5:0] c0;
   reg [3:0] p;
   ////////////////////////////////////////////////////////////////
   apc_attribute_palette i_apc_attribute_palette (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_write_in(hw), .host_wdata_in(hwd),
      .host_read_in(hr), .host_rdata_out(rdat), .host_rdata_oe_out(rd_oe),
      .display_enable_in(de), .vertical_retrace_in(vr), .blank_in(blank),
      .line_graphics_in(lg), .cursor_in(cur), .ninth_dot_in(nd),
      .foreground_attribute_bits_in(fg), .background_attribute_bits_in(bg),
      .condition_select_in(cs), .colour_out(col), .colour_oe_out(oe));
   apc_host_model u_host (
      .clk_sys_in(clk_sys_in), .host_rdata_in(rdat), .host_rdata_oe_in(rd_oe),
      .host_write_out(hw), .host_wdata_out(hwd), .host_read_out(hr),
      .vertical_retrace_out(vr));
   ////////////////////////////////////////////////////////////////
   // 250 MHz clock
   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   // Hang guard
   always @(posedge clk_sys_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   end
   // Distinct nonzero palette value per entry
   function [5:0] pv(input [3:0] k);
      pv = {k, 2'b10} ^ 6'h15;
   endfunction
   // Compare and count
   task chk(input string nm, input [5:0] got, input [5:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // Let the pixel pipeline fill
   task settle;
      repeat (16) @(negedge clk_sys_in);
   endtask
   // Cycles until a one-pel marker shows
   task lat(output integer n);
      begin
         fg = 4'h0;
         settle;
         fg = 4'h1;
         @(negedge clk_sys_in);
         fg = 4'h0;
         n = 0;
         while (col !== pv(4'h1) && n < 40) begin
            @(negedge clk_sys_in);
            n = n + 1;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Status bits follow enable and retrace
   task t_status;
      begin
         u_host.rd(st);
         chk("stat_oe", st[6], 1'b1);
         chk("stat_de", st[3:0], 4'h0);
         de = 1'b0;
         u_host.rt(1'b1);
         u_host.rd(st);
         chk("stat_rt", st[3:0], 4'h9);
         u_host.rt(1'b0);
         de = 1'b1;
      end
   endtask
   // Load palette, check gating and every entry
   task t_palette;
      begin
         u_host.rt(1'b1);
         for (i = 0; i < 16; i = i + 1) u_host.set(i[5:0], pv(i[3:0]));
         u_host.set(6'h21, 6'h3f);
         u_host.rt(1'b0);
         fg = 4'h1;
         u_host.set(6'h12, 6'h0f);
         settle;
         chk("pal_off", col, 6'h00);
         u_host.set(6'h30, 6'h00);
         for (i = 0; i < 16; i = i + 1) begin
            fg = i[3:0];
            settle;
            chk("pal", col, pv(i[3:0]));
         end
      end
   endtask
   // Select bit, intensity, plane mask, ninth dot
   task t_select;
      begin
         cs = 1'b0;
         bg = 4'hb;
         settle;
         chk("bg_sel", col, pv(4'hb));
         cs = 1'b1;
         fg = 4'hf;
         u_host.set(6'h32, 6'h07);
         settle;
         chk("planes", col, pv(4'h7));
         u_host.set(6'h32, 6'h0f);
         fg = 4'h1;
         bg = 4'h2;
         nd = 1'b1;
         settle;
         chk("ninth_bg", col, pv(4'h2));
         u_host.set(6'h30, 6'h04);
         lg = 1'b1;
         settle;
         chk("ninth_lg", col, pv(4'h1));
         u_host.set(6'h30, 6'h00);
         nd = 1'b0;
         lg = 1'b0;
      end
   endtask
   // Border colour, and a read restarting the pair
   task t_border;
      begin
         de = 1'b0;
         u_host.set(6'h31, 6'h2d);
         settle;
         chk("border", col, 6'h2d);
         blank = 1'b1;
         settle;
         chk("blank", col, 6'h00);
         blank = 1'b0;
         u_host.wr(6'h31);
         u_host.rd(st);
         u_host.wr(6'h31);
         u_host.wr(6'h16);
         settle;
         chk("toggle", col, 6'h16);
         de = 1'b1;
      end
   endtask
   // Status colour pairs and output float
   task t_stat_colour;
      begin
         fg = 4'hc;
         for (i = 0; i < 3; i = i + 1) begin
            u_host.set(6'h32, {i[1:0], 4'hf});
            settle;
            u_host.rd(st);
            c0 = pv(4'hc);
            chk("pair", st[5:4], i == 0 ? {c0[2], c0[0]} :
               i == 1 ? {c0[3], c0[1]} : {c0[5], c0[4]});
            chk("float", oe, i != 1);
         end
         u_host.set(6'h32, 6'h0f);
      end
   endtask
   // Graphics blink swaps attribute bit 3 every 16 retraces
   task t_blink;
      begin
         u_host.set(6'h30, 6'h09);
         fg = 4'h3;
         settle;
         chk("blink0", col, pv(4'h3));
         repeat (15) begin
            u_host.rt(1'b1);
            u_host.rt(1'b0);
         end
         settle;
         chk("blink15", col, pv(4'h3));
         u_host.rt(1'b1);
         u_host.rt(1'b0);
         settle;
         chk("blink16", col, pv(4'hb));
         u_host.set(6'h30, 6'h00);
      end
   endtask
   // Cursor forces foreground, 8 retraces on, 8 off; plane bit 4 clears it
   task t_cursor;
      begin
         cs = 1'b0;
         fg = 4'h1;
         bg = 4'h2;
         cur = 1'b1;
         for (i = 0; i < 3; i = i + 1) begin
            if (i != 1) begin
               u_host.set(6'h32, 6'h1f);
               u_host.set(6'h32, 6'h0f);
            end else begin
               repeat (8) begin
                  u_host.rt(1'b1);
                  u_host.rt(1'b0);
               end
            end
            settle;
            chk("cursor", col, i == 1 ? pv(4'h2) : pv(4'h1));
         end
         cur = 1'b0;
         cs = 1'b1;
      end
   endtask
   // Pan moves the marker earlier, clamped at the mode limit
   task t_pan;
      begin
         lat(n0);
         for (i = 0; i < 4; i = i + 1) begin
            p = i == 0 ? 4'h3 : i == 1 ? 4'h8 : 4'hc;
            if (i == 3) u_host.set(6'h30, 6'h02);
            u_host.set(6'h33, {2'b00, p});
            lat(n1);
            chk("pan", 6'(n0 - n1), i == 3 ? 6'h09 : p > 4'h8 ? 6'h08 : {2'b00, p});
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task report_and_stop;
      begin
         $display("Checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      rst_in = 1'b1;
      de = 1'b1;
      blank = 1'b0;
      lg = 1'b0;
      nd = 1'b0;
      cs = 1'b1;
      cur = 1'b0;
      fg = 4'h0;
      bg = 4'h0;
      repeat (6) @(negedge clk_sys_in);
      rst_in = 1'b0;
      settle;
      chk("rst_oe", oe, 1'b1);
      chk("rst_col", col, 6'h00);
      t_status;
      t_palette;
      t_select;
      t_border;
      t_stat_colour;
      t_blink;
      t_cursor;
      t_pan;
      report_and_stop;
   end
endmodule // apc_attribute_palette_tb

// *** tb/apc_checker_props.sv ***
// Port checker for the attribute and palette stage.
// Assumes one clock domain and the fixed pixel delay of the design.
`timescale 1ns/1ps

module apc_checker (
   input wire clk_sys_in,
   input wire rst_in,
   input wire host_write_in,
   input wire host_read_in,
   input wire [5:0] host_rdata_out,
   input wire host_rdata_oe_out,
   input wire display_enable_in,
   input wire vertical_retrace_in,
   input wire blank_in,
   input wire [5:0] colour_out,
   input wire colour_oe_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////
   // Status read taken at an edge
   sequence s_read;
      host_read_in;
   endsequence
   // Read held over two edges
   sequence s_read_run;
      host_read_in ##1 host_read_in;
   endsequence
   ////////////////////////////////////////////////////////////////
   a_status_oe_rise: assert property (s_read |=> host_rdata_oe_out)
      else $error("status enable missing after read");
   a_status_oe_fall: assert property (!host_read_in |=> !host_rdata_oe_out)
      else $error("status enable without read");
   a_status_oe_hold: assert property (s_read_run |-> host_rdata_oe_out)
      else $error("status enable dropped during read");
   a_status_de_low: assert property (s_read |=>
      host_rdata_out[0] == !$past(display_enable_in))
      else $error("status bit 0 not inverted enable");
   a_status_retrace: assert property (s_read |=>
      host_rdata_out[3] == $past(vertical_retrace_in))
      else $error("status bit 3 not retrace");
   a_status_spare: assert property (host_rdata_oe_out |-> host_rdata_out[2:1] == 2'b00)
      else $error("status spare bits set");
   a_blank_dark: assert property (blank_in |-> ##12 colour_out == 6'h00)
      else $error("colour shown while blanked");
   a_oe_cause: assert property ($changed(colour_oe_out) |-> $past(host_write_in))
      else $error("colour enable changed without write");
endmodule // apc_checker

bind apc_attribute_palette apc_checker i_apc_checker (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_write_in(host_write_in),
   .host_read_in(host_read_in), .host_rdata_out(host_rdata_out),
   .host_rdata_oe_out(host_rdata_oe_out), .display_enable_in(display_enable_in),
   .vertical_retrace_in(vertical_retrace_in), .blank_in(blank_in),
   .colour_out(colour_out), .colour_oe_out(colour_oe_out));

// *** tb/apc_host_model.sv ***
// Host processor and retrace source facing the stage.
// Assumes strobes change on the falling clock edge.
`timescale 1ns/1ps

module apc_host_model (
   input wire clk_sys_in,
   input wire [5:0] host_rdata_in,
   input wire host_rdata_oe_in,
   output reg host_write_out,
   output reg [5:0] host_wdata_out,
   output reg host_read_out,
   output reg vertical_retrace_out
);
   // Idle bus at time zero
   initial begin
      host_write_out = 1'b0;
      host_wdata_out = 6'h2a;
      host_read_out = 1'b0;
      vertical_retrace_out = 1'b0;
   end
   // One write pulse; data inverted once released
   task wr(input [5:0] v);
      begin
         @(negedge clk_sys_in);
         host_write_out = 1'b1;
         host_wdata_out = v;
         @(negedge clk_sys_in);
         host_write_out = 1'b0;
         host_wdata_out = ~v;
      end
   endtask
   // Status read, returns enable and data
   task rd(output [6:0] st);
      begin
         @(negedge clk_sys_in);
         host_read_out = 1'b1;
         @(negedge clk_sys_in);
         st = {host_rdata_oe_in, host_rdata_in};
         host_read_out = 1'b0;
      end
   endtask
   // Read restarts the pair, then index and data
   task set(input [5:0] idx, input [5:0] v);
      reg [6:0] s;
      begin
         rd(s);
         wr(idx);
         wr(v);
      end
   endtask
   // Retrace level; palette loads happen while high
   task rt(input lvl);
      begin
         @(negedge clk_sys_in);
         vertical_retrace_out = lvl;
      end
   endtask
endmodule // apc_host_model
